//--- dv/eic_src.sv
// Behavioural signal sources on the six external interrupt pins
`timescale 1ns/1ns
`default_nettype none
module eic_src (
  input wire logic sys_clk_i,
  output logic [5:0] pins_o
);
  // Idle: a and f high (falling edge is their event), b..e low
  initial pins_o = 6'h21;

  // Move one pin just after a falling edge, clear of the sample edge
  task automatic put(input int idx, input logic v);
    @(negedge sys_clk_i);
    pins_o[idx] = v;
  endtask : put

  // Pulse away from idle for len cycles, then back
  task automatic pulse(input int idx, input int len);
    logic idle;
    idle = pins_o[idx];
    put(idx, !idle);
    repeat (len - 1) @(negedge sys_clk_i);
    put(idx, idle);
  endtask : pulse
endmodule : eic_src
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench of the external interrupt conditioner
`timescale 1ns/1ns
`default_nettype none
module tb_top import eic_pkg::*; ;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic slow_mode_i = 1'b0;
  logic [5:0] sfr_addr_i = 6'h00;
  logic sfr_wr_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic mie = 1'b1;
  logic [5:0] ena = 6'h3F;
  logic csel = 1'b1;
  logic [5:0] clr_i = 6'h00;
  logic [7:0] rdata;
  logic [5:0] latch;
  logic [5:0] req;
  logic [5:0] pins;
  logic port_bit;
  logic a_act;
  int fail_count = 0;
  int n_checks = 0;
  localparam logic [5:0] ADR = EIC_CTRL_ADDR;

  // 20 MHz clock
  always #25 sys_clk_i = ~sys_clk_i;

  eic_src i_src (.sys_clk_i(sys_clk_i), .pins_o(pins));
  eic_top i_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .ext_irq_i(pins), .slow_mode_i(slow_mode_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(rdata),
    .master_irq_enable_i(mie), .irq_enable_reg_i(ena),
    .irq_c_source_sel_i(csel), .irq_latch_clr_i(clr_i),
    .irq_latch_o(latch), .irq_req_o(req),
    .shared_port_bit_o(port_bit), .irq_a_active_o(a_act));

  // ********
  // Helpers
  // ********
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : cyc

  task automatic clr;
    cyc(1);
    clr_i = 6'h3F;
    cyc(1);
    clr_i = 6'h00;
  endtask : clr

  // Writes end with a latch clear so no stale event leaks onward
  task automatic wreg(input logic [5:0] a, input logic [7:0] d);
    cyc(1);
    sfr_addr_i = a;
    sfr_wr_i = 1'b1;
    sfr_wdata_i = d;
    cyc(1);
    sfr_wr_i = 1'b0;
    clr;
  endtask : wreg

  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    cyc(1);
    sfr_addr_i = a;
    cyc(1);
    chk(rdata, e);
  endtask : rchk

  task automatic lchk(input int i, input logic e);
    chk({7'h00, latch[i]}, {7'h00, e});
  endtask : lchk

  task automatic pchk(input int i, input int n, input logic e, input int w);
    i_src.pulse(i, n);
    cyc(w);
    lchk(i, e);
    clr;
  endtask : pchk

  // ********
  // Scenarios
  // ********
  task automatic t_reg;
    chk({7'h00, a_act}, 8'h00);
    chk({7'h00, port_bit}, 8'h01);
    rchk(ADR, EIC_CTRL_RST);
    pchk(0, 20, 1'b0, 300);
    wreg(ADR, 8'hFF);
    rchk(ADR, 8'hFE);
    wreg(6'h36, 8'h00);
    rchk(6'h36, 8'h00);
    rchk(ADR, 8'hFE);
    chk({7'h00, a_act}, 8'h01);
    // Pin a stays an input, so the interrupt role is safe
    wreg(ADR, 8'h40);
    $display("done: register");
  endtask : t_reg

  task automatic t_width;
    pchk(0, 1, 1'b0, 300);
    pchk(0, 7, 1'b1, 300);
    pchk(5, 1, 1'b0, 300);
    pchk(5, 7, 1'b1, 300);
    for (int i = 2; i < 5; i++)
    begin
      pchk(i, 6, 1'b0, 300);
      pchk(i, 25, 1'b1, 300);
    end
    wreg(ADR, 8'hC0);
    pchk(1, 14, 1'b0, 300);
    pchk(1, 49, 1'b1, 300);
    wreg(ADR, 8'h40);
    cyc(26);
    pchk(1, 62, 1'b0, 300);
    pchk(1, 193, 1'b1, 400);
    $display("done: widths");
  endtask : t_width

  task automatic t_gate;
    i_src.pulse(0, 7);
    i_src.pulse(2, 25);
    cyc(600);
    chk({2'h0, req}, 8'h05);
    csel = 1'b0;
    cyc(1);
    chk({2'h0, req}, 8'h01);
    ena = 6'h3E;
    cyc(1);
    chk({2'h0, req}, 8'h00);
    ena = 6'h3F;
    csel = 1'b1;
    mie = 1'b0;
    cyc(1);
    chk({2'h0, req}, 8'h00);
    chk({2'h0, latch}, 8'h05);
    mie = 1'b1;
    clr;
    chk({2'h0, latch}, 8'h00);
    $display("done: gating");
  endtask : t_gate

  task automatic t_edge;
    wreg(ADR, 8'h4E);
    for (int i = 1; i < 4; i++)
    begin
      i_src.put(i, 1'b1);
      cyc(300);
      lchk(i, 1'b0);
      i_src.put(i, 1'b0);
      cyc(300);
      lchk(i, 1'b1);
      clr;
    end
    for (int m = 0; m < 4; m++)
    begin
      wreg(ADR, {2'b01, 2'(m), 4'h0});
      i_src.put(4, 1'b1);
      cyc(300);
      lchk(4, m != 1);
      clr;
      i_src.put(4, 1'b0);
      cyc(300);
      lchk(4, m != 0);
      clr;
    end
    $display("done: edges");
  endtask : t_edge

  task automatic t_slow;
    int k;
    wreg(ADR, 8'h40);
    i_src.put(0, 1'b0);
    for (k = 0; k < 8 + 6 * FS_DIV_CYC && latch[0] !== 1'b1; k++)
      cyc(1);
    lchk(0, 1'b1);
    chk({7'h00, port_bit}, 8'h00);
    if (k == 8 + 6 * FS_DIV_CYC)
      conclude();
    clr;
    i_src.put(0, 1'b1);
    cyc(300);
    lchk(0, 1'b0);
    // Interrupts masked across the clock switch
    mie = 1'b0;
    slow_mode_i = 1'b1;
    cyc(10);
    mie = 1'b1;
    pchk(0, 300, 1'b0, 3000);
    pchk(0, FS_DIV_CYC * 7 / 2, 1'b1, 3000);
    slow_mode_i = 1'b0;
    cyc(10);
    $display("done: slow");
  endtask : t_slow

  task automatic t_level;
    i_src.put(4, 1'b1);
    nrst_i = 1'b0;
    cyc(20);
    nrst_i = 1'b1;
    chk({7'h00, a_act}, 8'h00);
    wreg(ADR, 8'h70);
    cyc(300);
    lchk(4, 1'b0);
    i_src.pulse(4, 100);
    i_src.put(4, 1'b1);
    cyc(300);
    lchk(4, 1'b1);
    $display("done: level");
  endtask : t_level

  task automatic conclude;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // Main sequence
  initial
  begin
    cyc(20);
    nrst_i = 1'b1;
    cyc(2);
    t_reg();
    t_width();
    t_gate();
    t_edge();
    t_slow();
    t_level();
    conclude();
  end

  // Run limit: a hang counts as a mismatch
  initial
  begin
    #5_000_000;
    $display("unexpected at %0t: run limit", $time);
    fail_count++;
    conclude();
  end
endmodule : tb_top
`default_nettype wire

//--- src/eic_pkg.sv
// Constants, field layout and types of the external interrupt conditioner
package eic_pkg;

  // ************************************************************
  // Register map and reset
  // ************************************************************
  localparam logic [5:0] EIC_CTRL_ADDR = 6'h37;
  localparam logic [7:0] EIC_CTRL_RST = 8'h00;
  localparam int N_IRQ = 6;
  localparam int IRQ_A = 0;
  localparam int IRQ_B = 1;
  localparam int IRQ_C = 2;
  localparam int IRQ_D = 3;
  localparam int IRQ_E = 4;
  localparam int IRQ_F = 5;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic noise_time_sel;
    logic pin_function_sel;
    logic [1:0] irq_e_sense_sel;
    logic irq_d_edge_sel;
    logic irq_c_edge_sel;
    logic irq_b_edge_sel;
    logic spare;
  } eic_ctrl_t;

  // Sense modes of the fifth input, in field order
  typedef enum logic [1:0] {
    SENSE_RISE,
    SENSE_FALL,
    SENSE_BOTH,
    SENSE_HIGH
  } eic_sense_t;

  // ************************************************************
  // Timing: fc is the system clock, fs comes from a divider
  // ************************************************************
  localparam int FC_HZ = 20_000_000;
  localparam int FS_HZ = 32_768;
  localparam int FS_DIV_CYC = FC_HZ / FS_HZ;
  // Accept times in fc periods; the filter passes one period earlier
  localparam int ACC_AF_FC = 7;
  localparam int ACC_CDE_FC = 25;
  localparam int ACC_B_SHORT_FC = 49;
  localparam int ACC_B_LONG_FC = 193;
  localparam int REJ_SLOW_FS = 1;
  localparam logic [7:0] THR_AF = 8'(ACC_AF_FC - 1);
  localparam logic [7:0] THR_CDE = 8'(ACC_CDE_FC - 1);
  localparam logic [7:0] THR_B_SHORT = 8'(ACC_B_SHORT_FC - 1);
  localparam logic [7:0] THR_B_LONG = 8'(ACC_B_LONG_FC - 1);
  localparam logic [7:0] THR_SLOW = 8'(REJ_SLOW_FS + 1);

endpackage : eic_pkg

//--- src/eic_top.sv
// External interrupt conditioner: pin filters, edge select and latches
`timescale 1ns/1ns
`default_nettype none
module eic_top
  import eic_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [5:0] ext_irq_i,
  input wire logic slow_mode_i,
  input wire logic [5:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic master_irq_enable_i,
  input wire logic [5:0] irq_enable_reg_i,
  input wire logic irq_c_source_sel_i,
  input wire logic [5:0] irq_latch_clr_i,
  output logic [5:0] irq_latch_o,
  output logic [5:0] irq_req_o,
  output logic shared_port_bit_o,
  output logic irq_a_active_o
);

  // ************************************************************
  // Control register
  // ************************************************************
  eic_ctrl_t ctrl;
  eic_sense_t sense;
  assign sense = eic_sense_t'(ctrl.irq_e_sense_sel);

  // Single byte register; reset leaves the shared pin a port
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ctrl <= eic_ctrl_t'(EIC_CTRL_RST);
    else if (sfr_wr_i && sfr_addr_i == EIC_CTRL_ADDR)
      ctrl <= eic_ctrl_t'(sfr_wdata_i);
  end

  // Registered read; bit 0 is don't care and reads zero
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sfr_rdata_o <= 8'h00;
    else if (sfr_addr_i == EIC_CTRL_ADDR)
      sfr_rdata_o <= {ctrl[7:1], 1'b0};
    else
      sfr_rdata_o <= 8'h00;
  end

  // Pin role output straight from the register
  assign irq_a_active_o = ctrl.pin_function_sel;

  // ************************************************************
  // Low-frequency tick divider
  // ************************************************************
  logic [15:0] fs_cnt;
  logic fs_tick;
  logic tick;

  // fs is made here as an enable so one clock serves all modes
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      fs_cnt <= 16'h0000;
      fs_tick <= 1'b0;
    end
    else if (fs_cnt == 16'(FS_DIV_CYC - 1))
    begin
      fs_cnt <= 16'h0000;
      fs_tick <= 1'b1;
    end
    else
    begin
      fs_cnt <= fs_cnt + 16'h0001;
      fs_tick <= 1'b0;
    end
  end

  // In slow and sleep the filter counts fs ticks instead of fc
  assign tick = slow_mode_i ? fs_tick : 1'b1;

  // ************************************************************
  // Noise filters
  // ************************************************************
  logic [7:0] thr [N_IRQ];
  logic s1 [N_IRQ];
  logic s2 [N_IRQ];
  logic filt [N_IRQ];
  logic filt_d [N_IRQ];
  logic init [N_IRQ];
  logic pv [N_IRQ];
  logic [7:0] cnt [N_IRQ];
  logic [1:0] warm;

  // Thresholds follow the register at once, well inside 26 fc
  always_comb
  begin
    thr[IRQ_A] = THR_AF;
    thr[IRQ_F] = THR_AF;
    thr[IRQ_B] = ctrl.noise_time_sel ? THR_B_SHORT : THR_B_LONG;
    thr[IRQ_C] = THR_CDE;
    thr[IRQ_D] = THR_CDE;
    thr[IRQ_E] = THR_CDE;
    if (slow_mode_i)
    begin
      for (int i = 0; i < N_IRQ; i++)
        thr[i] = THR_SLOW;
    end
  end

  // Two cycles after reset s2 holds the pin, so filters may load then
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      warm <= 2'h0;
    else
      warm <= {warm[0], 1'b1};
  end

  for (genvar g = 0; g < N_IRQ; g++)
  begin : g_pin
    // Pins are asynchronous: two flops before any logic
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        s1[g] <= 1'b0;
        s2[g] <= 1'b0;
      end
      else
      begin
        s1[g] <= ext_irq_i[g];
        s2[g] <= s1[g];
      end
    end

    // Level must differ for thr ticks in a row before it is taken;
    // filters reload until s2 holds the pin, so a high pin is no edge
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        init[g] <= 1'b0;
        filt[g] <= 1'b0;
        cnt[g] <= 8'h00;
      end
      else if (!init[g])
      begin
        init[g] <= warm[1];
        filt[g] <= s2[g];
      end
      else if (s2[g] == filt[g])
        cnt[g] <= 8'h00;
      else if (tick)
      begin
        // >= so a shortened threshold also takes a long count
        if (cnt[g] >= thr[g] - 8'h01)
        begin
          filt[g] <= s2[g];
          cnt[g] <= 8'h00;
        end
        else
          cnt[g] <= cnt[g] + 8'h01;
      end
    end

    // Previous filtered level for the edge detectors
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
      if (!nrst_i)
      begin
        filt_d[g] <= 1'b0;
        pv[g] <= 1'b0;
      end
      else
      begin
        filt_d[g] <= filt[g];
        pv[g] <= init[g];
      end
    end
  end

  // ************************************************************
  // Edge and level qualification
  // ************************************************************
  logic [5:0] rise;
  logic [5:0] fall;
  logic [5:0] ev;
  logic armed;

  // Edges are seen only once the filter has a valid history
  always_comb
  begin
    for (int i = 0; i < N_IRQ; i++)
    begin
      rise[i] = pv[i] && filt[i] && !filt_d[i];
      fall[i] = pv[i] && !filt[i] && filt_d[i];
    end
  end

  // Level mode arms only on a rising edge seen after reset
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      armed <= 1'b0;
    else if (rise[IRQ_E])
      armed <= 1'b1;
  end

  // Per-input event selection
  always_comb
  begin
    ev[IRQ_A] = fall[IRQ_A] && ctrl.pin_function_sel;
    ev[IRQ_B] = ctrl.irq_b_edge_sel ? fall[IRQ_B] : rise[IRQ_B];
    ev[IRQ_C] = ctrl.irq_c_edge_sel ? fall[IRQ_C] : rise[IRQ_C];
    ev[IRQ_D] = ctrl.irq_d_edge_sel ? fall[IRQ_D] : rise[IRQ_D];
    ev[IRQ_F] = fall[IRQ_F];
    unique case (sense)
      SENSE_RISE: ev[IRQ_E] = rise[IRQ_E];
      SENSE_FALL: ev[IRQ_E] = fall[IRQ_E];
      SENSE_BOTH: ev[IRQ_E] = rise[IRQ_E] || fall[IRQ_E];
      SENSE_HIGH: ev[IRQ_E] = armed && filt[IRQ_E];
    endcase
  end

  // ************************************************************
  // Latches and request gating
  // ************************************************************
  // A new event beats a clear in the same cycle so none is lost
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      irq_latch_o <= 6'h00;
    else
      irq_latch_o <= (irq_latch_o & ~irq_latch_clr_i) | ev;
  end

  // Enable flags mask glitches caused by port output changes
  always_comb
  begin
    irq_req_o = irq_latch_o & irq_enable_reg_i;
    if (!master_irq_enable_i)
      irq_req_o = 6'h00;
    if (!irq_c_source_sel_i)
      irq_req_o[IRQ_C] = 1'b0;
  end

  // The shared pin read back as a plain synchronised port bit
  assign shared_port_bit_o = s2[IRQ_A];

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_a_fall_live;
    fall[IRQ_A] && ctrl.pin_function_sel;
  endsequence

  sequence s_a_pending;
    (pv[IRQ_A] && s2[IRQ_A] != filt[IRQ_A] && !slow_mode_i)[*6];
  endsequence

  a_ctrl_reset: assert property (@(posedge sys_clk_i)
    $rose(nrst_i) |-> ctrl == eic_ctrl_t'(EIC_CTRL_RST))
    else $error("control register not at reset value");

  a_port_blocks: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    (!ctrl.pin_function_sel && !irq_latch_o[IRQ_A]) |=> !irq_latch_o[IRQ_A])
    else $error("latch a set while pin is a port");

  a_a_latches: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    s_a_fall_live |=> irq_latch_o[IRQ_A])
    else $error("falling edge on a not latched");

  a_a_accept: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    s_a_pending |=> filt[IRQ_A] == $past(s2[IRQ_A]))
    else $error("seven-period pulse on a not accepted");

  a_cde_reject: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    ($past(pv[IRQ_C]) && $changed(filt[IRQ_C]) && !$past(slow_mode_i))
      |-> $past(cnt[IRQ_C]) >= THR_CDE - 8'h01)
    else $error("input c passed a short pulse");

  a_b_window: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    ($past(pv[IRQ_B]) && $changed(filt[IRQ_B]) && !$past(slow_mode_i))
      |-> $past(cnt[IRQ_B]) >= THR_B_SHORT - 8'h01)
    else $error("input b passed below the short time");

  a_slow_tick: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    ($past(pv[IRQ_F]) && $changed(filt[IRQ_F]) && $past(slow_mode_i))
      |-> $past(fs_tick) && $past(cnt[IRQ_F]) >= THR_SLOW - 8'h01)
    else $error("slow-mode filter moved off an fs tick");

  a_level_armed: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    (sense == SENSE_HIGH && !armed && !irq_latch_o[IRQ_E])
      |=> !irq_latch_o[IRQ_E])
    else $error("level request without prior rising edge");

  a_latch_hold: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    (irq_latch_o[IRQ_D] && !irq_latch_clr_i[IRQ_D]) |=> irq_latch_o[IRQ_D])
    else $error("latch d dropped without a clear");

  a_req_gate: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    irq_req_o[IRQ_C] |-> master_irq_enable_i && irq_c_source_sel_i
      && irq_enable_reg_i[IRQ_C] && irq_latch_o[IRQ_C])
    else $error("request c passed a closed gate");

endmodule : eic_top
`default_nettype wire
